/* File: logic/flcs_pkg.sv */
// Package for the fuse and lock configuration store.
// Assumes a single 25 MHz clock domain and synchronous active-low reset.
package flcs_pkg;

  // ==========================================================================
  // Byte select codes for the programmer read and write port
  localparam logic [1:0] SEL_LOCK     = 2'h0;
  localparam logic [1:0] SEL_EXT_FUSE = 2'h1;
  localparam logic [1:0] SEL_HIGH_FUSE= 2'h2;
  localparam logic [1:0] SEL_LOW_FUSE = 2'h3;

  // ==========================================================================
  // Values after reset; chip erase reloads only the lock byte
  localparam logic [7:0] LOCK_RESET      = 8'hFF;
  localparam logic [7:0] EXT_FUSE_RESET  = 8'hFF;
  localparam logic [7:0] HIGH_FUSE_RESET = 8'hDF;
  localparam logic [7:0] LOW_FUSE_RESET  = 8'h62;
  localparam logic [7:0] LOCK_UNUSED_MASK = 8'hFC;

  // ==========================================================================
  // Field positions
  localparam int LOCK_LOW_POS       = 0;
  localparam int LOCK_HIGH_POS      = 1;
  localparam int SELF_PROG_POS      = 0;
  localparam int RESET_DIS_POS      = 7;
  localparam int DEBUG_EN_POS       = 6;
  localparam int SERIAL_EN_POS      = 5;
  localparam int WDOG_ON_POS        = 4;
  localparam int EE_PRESERVE_POS    = 3;
  localparam int CLK_DIV8_POS       = 7;
  localparam int CLK_OUT_POS        = 6;

  // ==========================================================================
  // Signature space addresses
  localparam logic [1:0] SIG_ADDR_0 = 2'h0;
  localparam logic [1:0] SIG_ADDR_1 = 2'h1;
  localparam logic [1:0] SIG_ADDR_2 = 2'h2;

  // ==========================================================================
  // Memory geometry
  localparam int FLASH_WORD_BITS = 6;
  localparam int EE_BYTE_BITS    = 2;
  localparam int EE_ADDR_BITS    = 9;

  // Protection modes
  typedef enum logic [1:0] {
    FLCS_PROT_NONE,
    FLCS_PROT_WRITE,
    FLCS_PROT_FULL
  } flcs_prot_t;

  // Decoded active fuse settings; single-bit fields are active high, multi-bit fields are raw codes
  typedef struct packed {
    logic       self_program_enable;
    logic       external_reset_disable;
    logic       debug_link_enable;
    logic       serial_program_enable;
    logic       watchdog_always_on;
    logic       eeprom_preserve;
    logic [2:0] brownout_level;
    logic       clock_divide_by_eight;
    logic       clock_output_enable;
    logic [1:0] startup_time;
    logic [3:0] clock_source;
  } flcs_cfg_t;

  // Programmer request bundle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] sel;
    logic [7:0] data;
  } flcs_req_t;

endpackage

/* File: logic/flcs_nvm.sv */
// Four-byte nonvolatile fuse and lock storage with registered read data.
// Assumes writes come from the store's control logic on the same clock.
`timescale 1ns/1ps
module flcs_nvm (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [1:0] rd_addr,
  output logic [7:0]      rd_data,
  output logic [31:0]     all_bytes
);

  typedef struct packed {
    logic [3:0][7:0] mem;
    logic [7:0]      rd;
  } flcs_nvm_state_t;

  flcs_nvm_state_t st_r;
  flcs_nvm_state_t st_nxt;

  // ==========================================================================
  // Storage update; cells start unprogrammed-default after reset
  always_comb begin
    st_nxt    = st_r;
    st_nxt.rd = st_r.mem[rd_addr];
    if (wr_en) begin
      st_nxt.mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r.mem[flcs_pkg::SEL_LOCK]      <= flcs_pkg::LOCK_RESET;
      st_r.mem[flcs_pkg::SEL_EXT_FUSE]  <= flcs_pkg::EXT_FUSE_RESET;
      st_r.mem[flcs_pkg::SEL_HIGH_FUSE] <= flcs_pkg::HIGH_FUSE_RESET;
      st_r.mem[flcs_pkg::SEL_LOW_FUSE]  <= flcs_pkg::LOW_FUSE_RESET;
      st_r.rd                           <= 8'hFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data   = st_r.rd;
  assign all_bytes = st_r.mem;

endmodule

/* File: logic/flcs_store.sv */
// Fuse and lock configuration store: lock byte, three fuse bytes, signature,
// latched active configuration and memory geometry splitting.
// Assumes programmer strobes are one-cycle pulses on the same clock.
// Assumes prog_mode comes from a pin; two flops synchronise it.
// Assumes serial_mode and strobes come from logic on this clock.
// Cells are modelled as flops: reset reloads their defaults.
// Limitation: no page buffer or cell timing is modelled.
//
// Notes on behaviour
// (R1) Lock bits return to 1 only through chip erase.
// (R2) Lock byte uses bits 1:0; bits 7:2 read as 1; 0 is programmed.
// (R3) Both lock bits 1: no restriction.
// (R4) Mode 2: Flash/EEPROM writes refused, fuses locked.
// (R5) Mode 3: writes and reads of Flash/EEPROM refused, fuses locked.
// (R6) Undocumented lock pattern 01 treated as mode 3.
// (R7) Programmer should write fuses before locking.
// (R8) Store-program allowed only when self-program fuse reads 0.
// (R9) Fuse bits read 0 programmed, 1 unprogrammed.
// (R10) High fuse byte field layout as listed.
// (R11) Serial-program fuse not writable from serial programming.
// (R12) Preserve fuse programmed keeps EEPROM through chip erase.
// (R13) Low fuse layout; default clock source internal RC 8 MHz.
// (R14) Clock-output fuse drives system clock to the output pin.
// (R15) Fuses captured on programming entry; changes wait for exit.
// (R16) EEPROM-preserve fuse acts at once.
// (R17) Fuses captured at power-up in normal mode.
// (R18) Three-byte identification at addresses 0..2, readable when locked.
// (R19) Calibration byte copied into RC trim during reset.
// (R20) Flash 64-word pages: word PC[5:0], page PC[12:6] or PC[11:6].
// (R21) EEPROM 4-byte pages: byte addr[1:0], page addr[8:2].
`timescale 1ns/1ps
module flcs_store #(
  parameter logic [7:0] SIG_BYTE0  = 8'hA5, // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE1  = 8'h5A, // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE2  = 8'h3C, // Arbitrary identity value
  parameter logic [7:0] CAL_BYTE   = 8'h80, // Arbitrary trim default
  parameter int         PC_BITS    = 13
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Programmer interface
  input  wire logic                 prog_mode,
  input  wire logic                 serial_mode,
  input  wire flcs_pkg::flcs_req_t  req,
  input  wire logic                 chip_erase,
  input  wire logic                 sig_rd,
  input  wire logic [1:0]           sig_addr,
  input  wire logic                 cal_rd,
  // Core access requests
  input  wire logic                 mem_prog_req,
  input  wire logic                 mem_read_req,
  input  wire logic                 spm_req,
  input  wire logic                 sys_clk_in,
  input  wire logic [PC_BITS-1:0]   pc,
  input  wire logic [flcs_pkg::EE_ADDR_BITS-1:0] eeprom_byte_address,
  // Readback
  output logic [7:0]                rd_data,
  output logic                      rd_valid,
  output logic                      req_refused,
  // Decoded configuration and grants
  output flcs_pkg::flcs_cfg_t       cfg,
  output logic                      eeprom_erase_en,
  output logic                      mem_prog_ok,
  output logic                      mem_read_ok,
  output logic                      spm_ok,
  output flcs_pkg::flcs_prot_t      prot_mode,
  output logic [7:0]                rc_oscillator_trim,
  output logic                      clock_output_pin,
  // Geometry
  output logic [flcs_pkg::FLASH_WORD_BITS-1:0]       word_in_page_index,
  output logic [PC_BITS-flcs_pkg::FLASH_WORD_BITS-1:0] page_index,
  output logic [flcs_pkg::EE_BYTE_BITS-1:0]          ee_byte_in_page,
  output logic [flcs_pkg::EE_ADDR_BITS-flcs_pkg::EE_BYTE_BITS-1:0] ee_page_index
);

  // ==========================================================================
  // State
  // Every flop of this module outside u_nvm, copied into st_nxt each cycle
  typedef struct packed {
    logic [31:0] act;       // Latched fuse bytes and lock
    // Capture control and pin synchroniser
    logic        prog_d;
    logic        powered;
    logic        sync1;
    logic        sync2;
    // Readback path
    logic [7:0]  rdata;
    logic        rvalid;
    logic        refused;
    logic        rd_nvm;
    // Oscillator trim
    logic [7:0]  trim;
  } flcs_state_t;

  flcs_state_t st_r;
  flcs_state_t st_nxt;

  // Storage port
  logic        nvm_wr;
  logic [1:0]  nvm_waddr;
  logic [7:0]  nvm_wdata;
  logic [7:0]  nvm_rdata;
  logic [31:0] nvm_all;

  // Live and latched byte views
  logic [7:0]  lock_now;
  logic [7:0]  high_now;
  logic [7:0]  ext_act;
  logic [7:0]  high_act;
  logic [7:0]  low_act;

  // Shared lock decode result
  logic        fuses_locked;

  // ==========================================================================
  // Lock decode, shared by read refusal and write refusal
  // Unknown pattern fails closed: safer than granting access
  // Case codes are {upper bit, lower bit}
  function automatic flcs_pkg::flcs_prot_t lock_mode(input logic [7:0] lb);
    unique case ({lb[flcs_pkg::LOCK_HIGH_POS], lb[flcs_pkg::LOCK_LOW_POS]})
      2'h3:    lock_mode = flcs_pkg::FLCS_PROT_NONE;  // R3
      2'h2:    lock_mode = flcs_pkg::FLCS_PROT_WRITE; // R4
      2'h0:    lock_mode = flcs_pkg::FLCS_PROT_FULL;  // R5
      default: lock_mode = flcs_pkg::FLCS_PROT_FULL;  // R6
    endcase
  endfunction

  // Storage cells; read address follows the select
  flcs_nvm u_nvm (
    .clk       (clk),
    .rst_n     (rst_n),
    .wr_en     (nvm_wr),
    .wr_addr   (nvm_waddr),
    .wr_data   (nvm_wdata),
    .rd_addr   (req.sel),
    .rd_data   (nvm_rdata),
    .all_bytes (nvm_all)
  );

  // ==========================================================================
  // Live stored bytes; lock protection acts on the stored lock at once
  // A lock write restricts access from the next cycle
  assign lock_now     = nvm_all[8*flcs_pkg::SEL_LOCK +: 8];
  assign high_now     = nvm_all[8*flcs_pkg::SEL_HIGH_FUSE +: 8];
  assign prot_mode    = lock_mode(lock_now);
  assign fuses_locked = prot_mode != flcs_pkg::FLCS_PROT_NONE; // R4 R5

  // ==========================================================================
  // Writes into the store
  // Erase beats a write in the same cycle
  // Fuse bytes change only while both lock bits read 1
  always_comb begin
    nvm_wr    = 1'b0;
    nvm_waddr = req.sel;
    nvm_wdata = req.data;

    // Erase rewrites only the lock byte; fuses stay
    if (chip_erase) begin
      nvm_wr    = 1'b1;                    // R1
      nvm_waddr = flcs_pkg::SEL_LOCK;
      nvm_wdata = flcs_pkg::LOCK_RESET;
    end else if (req.wr) begin
      if (req.sel == flcs_pkg::SEL_LOCK) begin
        nvm_wr    = 1'b1;
        // Only clearing allowed: programmed bits never go back to 1
        nvm_wdata = (lock_now & req.data) | flcs_pkg::LOCK_UNUSED_MASK; // R1 R2
      end else if (!fuses_locked) begin
        nvm_wr = 1'b1;
        if (serial_mode && req.sel == flcs_pkg::SEL_HIGH_FUSE) begin
          // Serial session cannot alter the serial-program fuse
          nvm_wdata[flcs_pkg::SERIAL_EN_POS] = high_now[flcs_pkg::SERIAL_EN_POS]; // R11
        end
      end
    end
  end

  // ==========================================================================
  // Latching, readback, trim load
  always_comb begin
    st_nxt         = st_r;
    st_nxt.sync1   = prog_mode;
    st_nxt.sync2   = st_r.sync1;
    st_nxt.prog_d  = st_r.sync2;
    st_nxt.rvalid  = 1'b0;
    st_nxt.refused = 1'b0;
    st_nxt.rd_nvm  = 1'b0;

    // Capture at first cycle after reset and on mode entry and exit
    if (!st_r.powered) begin
      st_nxt.powered = 1'b1;
      st_nxt.act     = nvm_all;            // R17
      st_nxt.trim    = CAL_BYTE;           // R19
    end else if (st_r.sync2 != st_r.prog_d) begin
      // Exit releases the values written in the session
      st_nxt.act = nvm_all;                // R15
    end

    // Refused fuse write: one-cycle pulse
    if (req.wr && req.sel != flcs_pkg::SEL_LOCK && fuses_locked) begin
      st_nxt.refused = 1'b1;               // R4 R5
    end

    // Stored byte: strobe, cell register, output
    if (req.rd) begin
      st_nxt.rd_nvm = 1'b1;
    end
    if (st_r.rd_nvm) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = nvm_rdata;           // R9
    end

    // Identification readable regardless of locks
    if (sig_rd) begin
      st_nxt.rvalid = 1'b1;                // R18
      unique case (sig_addr)
        flcs_pkg::SIG_ADDR_0: st_nxt.rdata = SIG_BYTE0;
        flcs_pkg::SIG_ADDR_1: st_nxt.rdata = SIG_BYTE1;
        flcs_pkg::SIG_ADDR_2: st_nxt.rdata = SIG_BYTE2;
        default:              st_nxt.rdata = 8'hFF;
      endcase
    end else if (cal_rd) begin
      // Same byte the trim register is loaded with
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = CAL_BYTE;
    end
  end

  // Reset also loads the trim, so the oscillator
  // runs calibrated from the first cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Latched view starts from the default bytes
      st_r.act     <= {flcs_pkg::LOW_FUSE_RESET, flcs_pkg::HIGH_FUSE_RESET,
                       flcs_pkg::EXT_FUSE_RESET, flcs_pkg::LOCK_RESET};
      st_r.prog_d  <= 1'b0;
      st_r.powered <= 1'b0;
      st_r.sync1   <= 1'b0;
      st_r.sync2   <= 1'b0;
      st_r.rdata   <= 8'hFF;
      st_r.rvalid  <= 1'b0;
      st_r.refused <= 1'b0;
      st_r.rd_nvm  <= 1'b0;
      st_r.trim    <= CAL_BYTE;            // R19
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Active configuration from latched bytes (inverted: 0 means programmed)
  // Only the preserve fuse reads the live byte
  assign ext_act  = st_r.act[8*flcs_pkg::SEL_EXT_FUSE +: 8];
  assign high_act = st_r.act[8*flcs_pkg::SEL_HIGH_FUSE +: 8];
  assign low_act  = st_r.act[8*flcs_pkg::SEL_LOW_FUSE +: 8];

  always_comb begin
    // Extended fuse byte
    cfg.self_program_enable    = ~ext_act[flcs_pkg::SELF_PROG_POS];      // R8

    // High fuse byte
    cfg.external_reset_disable = ~high_act[flcs_pkg::RESET_DIS_POS];     // R10
    cfg.debug_link_enable      = ~high_act[flcs_pkg::DEBUG_EN_POS];
    cfg.serial_program_enable  = ~high_act[flcs_pkg::SERIAL_EN_POS];
    cfg.watchdog_always_on     = ~high_act[flcs_pkg::WDOG_ON_POS];
    // Preserve fuse bypasses the latch and acts as soon as stored
    cfg.eeprom_preserve        = ~high_now[flcs_pkg::EE_PRESERVE_POS];   // R16
    // Multi-bit fields pass as raw fuse codes
    cfg.brownout_level         = high_act[2:0];

    // Low fuse byte
    cfg.clock_divide_by_eight  = ~low_act[flcs_pkg::CLK_DIV8_POS];       // R13
    cfg.clock_output_enable    = ~low_act[flcs_pkg::CLK_OUT_POS];
    cfg.startup_time           = low_act[5:4];
    cfg.clock_source           = low_act[3:0];
  end

  // ==========================================================================
  // Outputs and access gating
  // Grants are combinational level responses
  assign eeprom_erase_en    = chip_erase && !cfg.eeprom_preserve;        // R12
  assign mem_prog_ok        = mem_prog_req && prot_mode == flcs_pkg::FLCS_PROT_NONE; // R4
  assign mem_read_ok        = mem_read_req && prot_mode != flcs_pkg::FLCS_PROT_FULL; // R5
  // Store-program gate uses the latched fuse
  assign spm_ok             = spm_req && cfg.self_program_enable;        // R8

  // Gated system clock; glitch hazard accepted as fuse is static in use
  // Pin stays low while the fuse is unprogrammed
  assign clock_output_pin   = cfg.clock_output_enable & sys_clk_in;      // R14

  // Registered readback and trim
  assign rd_data            = st_r.rdata;
  assign rd_valid           = st_r.rvalid;
  assign req_refused        = st_r.refused;
  assign rc_oscillator_trim = st_r.trim;

  // Memory geometry: flash word and page
  assign word_in_page_index = pc[flcs_pkg::FLASH_WORD_BITS-1:0];         // R20
  assign page_index         = pc[PC_BITS-1:flcs_pkg::FLASH_WORD_BITS];
  // EEPROM byte within a 4-byte page, page number
  assign ee_byte_in_page    = eeprom_byte_address[flcs_pkg::EE_BYTE_BITS-1:0]; // R21
  assign ee_page_index      = eeprom_byte_address[flcs_pkg::EE_ADDR_BITS-1:flcs_pkg::EE_BYTE_BITS];

endmodule

/* File: test/flcs_store_chk.sv */
// Port-level checker for the fuse and lock store.
// Assumes one clock domain and synchronous active-low reset.
`timescale 1ns/1ps
module flcs_store_chk #(
  parameter logic [7:0] CAL_BYTE = 8'h80,
  parameter int         PC_BITS  = 13
) (
  input wire logic                                      clk,
  input wire logic                                      rst_n,
  input wire flcs_pkg::flcs_req_t                       req,
  input wire logic                                      chip_erase,
  input wire logic                                      sig_rd,
  input wire logic                                      spm_req,
  input wire logic                                      sys_clk_in,
  input wire logic [PC_BITS-1:0]                        pc,
  input wire logic                                      rd_valid,
  input wire logic                                      req_refused,
  input wire flcs_pkg::flcs_cfg_t                       cfg,
  input wire logic                                      eeprom_erase_en,
  input wire logic                                      mem_prog_ok,
  input wire logic                                      mem_read_ok,
  input wire logic                                      spm_ok,
  input wire flcs_pkg::flcs_prot_t                      prot_mode,
  input wire logic [7:0]                                rc_oscillator_trim,
  input wire logic                                      clock_output_pin,
  input wire logic [flcs_pkg::FLASH_WORD_BITS-1:0]      word_in_page_index,
  input wire logic [PC_BITS-flcs_pkg::FLASH_WORD_BITS-1:0] page_index
);
  // ====================
  // Relations
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_erase_unlock; chip_erase |=> (prot_mode == flcs_pkg::FLCS_PROT_NONE) [*2]; endproperty
  a_erase_unlock: assert property (p_erase_unlock) else $error("lock kept after erase");
  property p_prog_block; prot_mode != flcs_pkg::FLCS_PROT_NONE |-> !mem_prog_ok; endproperty
  a_prog_block: assert property (p_prog_block) else $error("programming granted while locked");
  property p_read_block; prot_mode == flcs_pkg::FLCS_PROT_FULL |-> !mem_read_ok; endproperty
  a_read_block: assert property (p_read_block) else $error("read granted in full lock");
  property p_spm_gate; spm_ok |-> spm_req && cfg.self_program_enable; endproperty
  a_spm_gate: assert property (p_spm_gate) else $error("store-program granted without fuse");
  property p_clk_out; cfg.clock_output_enable |-> clock_output_pin == sys_clk_in; endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock not forwarded");
  property p_ee_keep; chip_erase |-> eeprom_erase_en == !cfg.eeprom_preserve; endproperty
  a_ee_keep: assert property (p_ee_keep) else $error("eeprom erase enable wrong");
  property p_pc_split; word_in_page_index == pc[5:0] && page_index == pc[PC_BITS-1:6]; endproperty
  a_pc_split: assert property (p_pc_split) else $error("flash address split wrong");
  property p_sig_lat; sig_rd |=> rd_valid; endproperty
  a_sig_lat: assert property (p_sig_lat) else $error("signature read not answered");
  property p_fuse_refuse;
    req.wr && req.sel != flcs_pkg::SEL_LOCK && prot_mode != flcs_pkg::FLCS_PROT_NONE && !chip_erase
      |=> req_refused;
  endproperty
  a_fuse_refuse: assert property (p_fuse_refuse) else $error("locked fuse write not refused");
  property p_trim; $rose(rst_n) |=> rc_oscillator_trim == CAL_BYTE; endproperty
  a_trim: assert property (p_trim) else $error("trim not loaded at reset");
  c_erase: cover property (chip_erase);
  c_refused: cover property (req_refused);
  c_spm: cover property (spm_ok);
endmodule
bind flcs_store flcs_store_chk #(.CAL_BYTE(CAL_BYTE), .PC_BITS(PC_BITS)) i_flcs_store_chk (
  .clk(clk), .rst_n(rst_n), .req(req), .chip_erase(chip_erase), .sig_rd(sig_rd), .spm_req(spm_req),
  .sys_clk_in(sys_clk_in), .pc(pc), .rd_valid(rd_valid), .req_refused(req_refused), .cfg(cfg),
  .eeprom_erase_en(eeprom_erase_en), .mem_prog_ok(mem_prog_ok), .mem_read_ok(mem_read_ok),
  .spm_ok(spm_ok), .prot_mode(prot_mode), .rc_oscillator_trim(rc_oscillator_trim),
  .clock_output_pin(clock_output_pin), .word_in_page_index(word_in_page_index), .page_index(page_index)
);

/* File: test/flcs_prog_model.sv */
// Programmer model: issues one-cycle request strobes to the store.
// Assumes the bench calls pulse; signals change 1 ns after clk rises.
`timescale 1ns/1ps
module flcs_prog_model (
  input  wire logic          clk,
  output flcs_pkg::flcs_req_t req,
  output logic               chip_erase,
  output logic               sig_rd,
  output logic [1:0]         sig_addr,
  output logic               cal_rd
);
  // ====================
  // Strobes idle low from time zero
  initial begin
    req = '0;
    chip_erase = 1'b0;
    sig_rd = 1'b0;
    sig_addr = 2'h0;
    cal_rd = 1'b0;
  end
  // Kind: 0 write, 1 read, 2 erase, 3 ident, 4 calibration
  task automatic pulse(input int kind, input logic [1:0] sel, input logic [7:0] data);
    @(posedge clk);
    #1;
    req = flcs_pkg::flcs_req_t'({kind == 0, kind == 1, sel, data});
    chip_erase = (kind == 2);
    sig_rd = (kind == 3);
    cal_rd = (kind == 4);
    sig_addr = sel;
    @(posedge clk);
    #1;
    // Released fields show the inverse, so stale values are never trusted
    req = flcs_pkg::flcs_req_t'({2'h0, ~sel, ~data});
    chip_erase = 1'b0;
    sig_rd = 1'b0;
    cal_rd = 1'b0;
    sig_addr = ~sel;
  endtask
endmodule

/* File: test/flcs_store_bench.sv */
// Self-checking bench for the fuse and lock store.
// Assumes flcs_prog_model drives the programmer side.
`timescale 1ns/1ps
module flcs_store_bench;
  localparam logic [7:0] ID0 = 8'h11; // Arbitrary identity value
  localparam logic [7:0] ID1 = 8'h22; // Arbitrary identity value
  localparam logic [7:0] ID2 = 8'h33; // Arbitrary identity value
  localparam logic [7:0] CAL = 8'h6B; // Arbitrary trim value
  logic clk, rst_n, prog_mode, serial_mode, mem_prog_req, mem_read_req, spm_req, sys_clk_in;
  logic [12:0] pc;
  logic [8:0] ee_addr;
  logic [7:0] rd_data, trim;
  logic rd_valid, req_refused, ee_erase, mem_prog_ok, mem_read_ok, spm_ok, clk_pin;
  logic [5:0] word_idx;
  logic [6:0] page_idx, ee_page;
  logic [1:0] ee_byte, sig_addr;
  logic chip_erase, sig_rd, cal_rd;
  flcs_pkg::flcs_req_t req;
  flcs_pkg::flcs_cfg_t cfg;
  flcs_pkg::flcs_prot_t prot;
  int num_errors, tests_run, cycles;
  logic [7:0] ids [3] = '{ID0, ID1, ID2};
  flcs_prog_model i_flcs_prog_model (.clk(clk), .req(req), .chip_erase(chip_erase), .sig_rd(sig_rd),
    .sig_addr(sig_addr), .cal_rd(cal_rd));
  flcs_store #(.SIG_BYTE0(ID0), .SIG_BYTE1(ID1), .SIG_BYTE2(ID2), .CAL_BYTE(CAL)) i_flcs_store (
    .clk(clk), .rst_n(rst_n), .prog_mode(prog_mode), .serial_mode(serial_mode), .req(req),
    .chip_erase(chip_erase), .sig_rd(sig_rd), .sig_addr(sig_addr), .cal_rd(cal_rd),
    .mem_prog_req(mem_prog_req), .mem_read_req(mem_read_req), .spm_req(spm_req),
    .sys_clk_in(sys_clk_in), .pc(pc), .eeprom_byte_address(ee_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .req_refused(req_refused), .cfg(cfg), .eeprom_erase_en(ee_erase),
    .mem_prog_ok(mem_prog_ok), .mem_read_ok(mem_read_ok), .spm_ok(spm_ok), .prot_mode(prot),
    .rc_oscillator_trim(trim), .clock_output_pin(clk_pin), .word_in_page_index(word_idx),
    .page_index(page_idx), .ee_byte_in_page(ee_byte), .ee_page_index(ee_page));
  // ====================
  // Clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      wrap_up();
    end
  end
  // ====================
  // Shared tasks
  task automatic note(input bit bad, input string what);
    tests_run++;
    if (bad) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    note(got !== exp, $sformatf("byte %h expected %h", got, exp));
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    note(got !== exp, "flag differs");
  endtask
  task automatic cmp_prot(input flcs_pkg::flcs_prot_t got, input flcs_pkg::flcs_prot_t exp);
    note(got !== exp, "protection mode differs");
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait: fuse reads answer later than ident reads
  task automatic rd_byte(input int kind, input logic [1:0] sel, input logic [7:0] exp);
    int n;
    i_flcs_prog_model.pulse(kind, sel, 8'h00);
    n = 0;
    while (rd_valid !== 1'b1 && n < 4) begin
      wait_cyc(1);
      n++;
    end
    cmp_bit(rd_valid, 1'b1);
    cmp_byte(rd_data, exp);
  endtask
  task automatic wr(input logic [1:0] sel, input logic [7:0] data);
    i_flcs_prog_model.pulse(0, sel, data);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ====================
  // Main sequence
  initial begin
    {clk, rst_n, prog_mode, serial_mode, sys_clk_in} = 5'h00;
    {mem_prog_req, mem_read_req, spm_req} = 3'h7;
    pc = 13'h1ABC;
    ee_addr = 9'h1F6;
    {num_errors, tests_run, cycles} = '0;
    wait_cyc(8);
    rst_n = 1'b1;
    wait_cyc(1);
    cmp_byte(trim, CAL);
    rd_byte(1, flcs_pkg::SEL_LOCK, 8'hFF);
    rd_byte(1, flcs_pkg::SEL_EXT_FUSE, 8'hFF);
    rd_byte(1, flcs_pkg::SEL_HIGH_FUSE, 8'hDF);
    rd_byte(1, flcs_pkg::SEL_LOW_FUSE, 8'h62);
    cmp_bit(cfg.serial_program_enable & cfg.clock_divide_by_eight, 1'b1);
    cmp_bit(mem_prog_ok & mem_read_ok, 1'b1);
    for (int i = 0; i < 3; i++) rd_byte(3, i[1:0], ids[i]);
    rd_byte(4, 2'h0, CAL);
    cmp_byte({2'h0, word_idx}, 8'h3C);
    cmp_byte({1'b0, page_idx}, 8'h6A);
    cmp_byte({6'h0, ee_byte}, 8'h02);
    cmp_byte({1'b0, ee_page}, 8'h7D);
    // Fuse session: only preserve acts before exit
    prog_mode = 1'b1;
    wait_cyc(5);
    wr(flcs_pkg::SEL_EXT_FUSE, 8'hFE);
    wr(flcs_pkg::SEL_LOW_FUSE, 8'h22);
    wr(flcs_pkg::SEL_HIGH_FUSE, 8'h97);
    wait_cyc(1);
    cmp_bit(cfg.eeprom_preserve, 1'b1);
    cmp_bit(cfg.debug_link_enable | spm_ok, 1'b0);
    serial_mode = 1'b1;
    wr(flcs_pkg::SEL_HIGH_FUSE, 8'hB7);
    rd_byte(1, flcs_pkg::SEL_HIGH_FUSE, 8'h97);
    serial_mode = 1'b0;
    prog_mode = 1'b0;
    wait_cyc(5);
    cmp_bit(cfg.debug_link_enable, 1'b1);
    cmp_bit(spm_ok, 1'b1);
    sys_clk_in = 1'b1;
    wait_cyc(1);
    cmp_bit(clk_pin, 1'b1);
    // Lock modes
    prog_mode = 1'b1;
    wait_cyc(5);
    wr(flcs_pkg::SEL_LOCK, 8'hFE);
    cmp_prot(prot, flcs_pkg::FLCS_PROT_WRITE);
    cmp_bit(mem_read_ok, 1'b1);
    wr(flcs_pkg::SEL_LOW_FUSE, 8'h00);
    cmp_bit(req_refused, 1'b1);
    rd_byte(1, flcs_pkg::SEL_LOW_FUSE, 8'h22);
    wr(flcs_pkg::SEL_LOCK, 8'hFF);
    rd_byte(1, flcs_pkg::SEL_LOCK, 8'hFE);
    wr(flcs_pkg::SEL_LOCK, 8'hFC);
    cmp_prot(prot, flcs_pkg::FLCS_PROT_FULL);
    rd_byte(1, flcs_pkg::SEL_LOCK, 8'hFC);
    rd_byte(3, 2'h1, ID1);
    i_flcs_prog_model.pulse(2, 2'h0, 8'h00);
    cmp_prot(prot, flcs_pkg::FLCS_PROT_NONE);
    wr(flcs_pkg::SEL_LOCK, 8'hFD);
    cmp_prot(prot, flcs_pkg::FLCS_PROT_FULL);
    wrap_up();
  end
endmodule
